// >>> gsl_act_blink.sv
// Purpose: Link and activity indicator blink sequencer
// Assumes: Activity is a same-clock pulse or level
// Notes:   Off phase then minimum solid phase, each a counted period
`timescale 1ns/1ns
`include "gsl_cfg.svh"
module gsl_act_blink
  import gsl_pkg::*;
#(
  parameter int unsigned ACT_CYCLES = `GSL_ACT_CYCLES
) (
  input  wire logic  clk,
  input  wire logic  reset,
  gsl_act_if.blinker act
);
  gsl_act_state_type state_r;
  gsl_act_state_type state_nxt;
  logic [31:0]       cnt_r;
  logic [31:0]       cnt_nxt;
  logic              lit_n_r;
  logic              lit_n_nxt;
  wire               cnt_done = (cnt_r == ACT_CYCLES - 32'h1);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + 32'h1;
    lit_n_nxt = 1'b1;
    case (state_r)
      GSL_ACT_SOLID: begin
        cnt_nxt   = 32'h0;
        lit_n_nxt = ~act.link_up;
        if (act.link_up && act.activity) begin
          state_nxt = GSL_ACT_OFF;
          lit_n_nxt = 1'b1;
        end
      end
      GSL_ACT_OFF: begin
        lit_n_nxt = 1'b1;
        if (!act.link_up) begin
          state_nxt = GSL_ACT_SOLID;
          cnt_nxt   = 32'h0;
        end else if (cnt_done) begin
          state_nxt = GSL_ACT_HOLD;
          cnt_nxt   = 32'h0;
          lit_n_nxt = 1'b0;
        end
      end
      GSL_ACT_HOLD: begin
        lit_n_nxt = ~act.link_up;
        if (!act.link_up || cnt_done) begin
          state_nxt = GSL_ACT_SOLID;
          cnt_nxt   = 32'h0;
        end
      end
      default: begin
        state_nxt = GSL_ACT_SOLID;
        cnt_nxt   = 32'h0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= GSL_ACT_SOLID;
      cnt_r   <= 32'h0;
      lit_n_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      lit_n_r <= lit_n_nxt;
    end
  end

  assign act.lit_n = lit_n_r;
endmodule

// >>> gsl_act_if.sv
// Purpose: Carries activity blink signals between blink unit and top
// Assumes: Single clock domain
// Notes:   Top drives inputs, blink unit drives indicator level
`timescale 1ns/1ns
interface gsl_act_if;
  logic link_up;
  logic activity;
  logic lit_n;
  modport blinker (input link_up, input activity, output lit_n);
  modport top     (output link_up, output activity, input lit_n);
endinterface

// >>> gsl_board.sv
// Purpose: Board side of the pins
// Assumes: Pull-up on every pin
// Notes:   Optional driver per pin
`timescale 1ns/1ns
module gsl_board (
  input  wire logic [2:0] pin_o,
  input  wire logic [2:0] pin_oe,
  input  wire logic [2:0] ext_en,
  input  wire logic [2:0] ext_v,
  output logic      [2:0] pin_i
);
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & (ext_v | ~ext_en));
endmodule

// >>> gsl_cfg.svh
// Purpose: Constants for the pin and status indicator mux
// Assumes: 100 MHz clock
// Notes:   Mode codes, timing counts, reset values
`ifndef GSL_CFG_SVH
`define GSL_CFG_SVH
`define GSL_NUM_PINS        3
`define GSL_MODE_INPUT      2'h0
`define GSL_MODE_PUSH_PULL  2'h1
`define GSL_MODE_OPEN_DRAIN 2'h2
`define GSL_MODE_INDICATOR  2'h3
`define GSL_CLK_MHZ         100
`define GSL_ACT_MS          80
`define GSL_ACT_CYCLES      (`GSL_ACT_MS * 1000 * `GSL_CLK_MHZ)
`define GSL_OUT_RESET       3'h0
`define GSL_MODE_RESET      6'h0
`endif

// >>> gsl_gpio_led_mux.sv
// Purpose: Three general pins muxed with active-low status indicators
// Assumes: Mode and out values from the config register, status from PHY/MAC
// Notes:   Pin inputs pass three flip-flops; pad resolves level from enable
`timescale 1ns/1ns
`include "gsl_cfg.svh"
module gsl_gpio_led_mux
  import gsl_pkg::*;
#(
  parameter int unsigned NUM_PINS   = `GSL_NUM_PINS,
  parameter int unsigned ACT_CYCLES = `GSL_ACT_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic [2*NUM_PINS-1:0] pin_mode,
  input  wire logic [NUM_PINS-1:0]   pin_out_value,
  output logic      [NUM_PINS-1:0]   pin_in_value,
  input  wire logic                  link_up,
  input  wire logic                  negotiating,
  input  wire logic                  speed_100,
  input  wire logic                  full_duplex,
  input  wire logic                  activity,
  output logic      [NUM_PINS-1:0]   status_indicators_n,
  input  wire logic [NUM_PINS-1:0]   pin_i,
  output logic      [NUM_PINS-1:0]   pin_o,
  output logic      [NUM_PINS-1:0]   pin_oe
);
  gsl_act_if act_bus ();

  logic [NUM_PINS-1:0] sync1_r;
  logic [NUM_PINS-1:0] sync2_r;
  logic [NUM_PINS-1:0] in_r;
  logic [NUM_PINS-1:0] pin_o_r;
  logic [NUM_PINS-1:0] pin_oe_r;
  logic                speed_n_r;
  logic                duplex_n_r;
  logic [NUM_PINS-1:0] ind_n;

  wire speed_n_nxt  = ~(link_up && !negotiating && speed_100);
  wire duplex_n_nxt = ~(link_up && full_duplex);

  assign act_bus.link_up  = link_up && !negotiating;
  assign act_bus.activity = activity;

  gsl_act_blink #(
    .ACT_CYCLES (ACT_CYCLES)
  ) u_blink (
    .clk   (clk),
    .reset (reset),
    .act   (act_bus)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      speed_n_r  <= 1'b1;
      duplex_n_r <= 1'b1;
    end else begin
      speed_n_r  <= speed_n_nxt;
      duplex_n_r <= duplex_n_nxt;
    end
  end

  always_comb begin
    ind_n = '1;
    ind_n[0] = speed_n_r;
    if (NUM_PINS > 1) begin
      ind_n[1 % NUM_PINS] = act_bus.lit_n;
    end
    if (NUM_PINS > 2) begin
      ind_n[2 % NUM_PINS] = duplex_n_r;
    end
  end

  assign status_indicators_n = ind_n;

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      wire [1:0] mode     = pin_mode[2*g +: 2];
      wire       is_ind   = (mode == `GSL_MODE_INDICATOR);
      wire       is_pp    = (mode == `GSL_MODE_PUSH_PULL);
      wire       is_od    = (mode == `GSL_MODE_OPEN_DRAIN);
      wire       o_nxt    = is_ind ? 1'b0 : (is_pp & pin_out_value[g]);
      wire       oe_nxt   = is_ind ? ~ind_n[g]
                          : (is_pp | (is_od & ~pin_out_value[g]));
      wire       in_nxt   = is_ind ? 1'b0 : sync2_r[g];

      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          sync1_r[g]  <= 1'b0;
          sync2_r[g]  <= 1'b0;
          in_r[g]     <= 1'b0;
          pin_o_r[g]  <= 1'b0;
          pin_oe_r[g] <= 1'b0;
        end else begin
          sync1_r[g]  <= pin_i[g];
          sync2_r[g]  <= sync1_r[g];
          in_r[g]     <= in_nxt;
          pin_o_r[g]  <= o_nxt;
          pin_oe_r[g] <= oe_nxt;
        end
      end
    end
  endgenerate

  assign pin_in_value = in_r;
  assign pin_o        = pin_o_r;
  assign pin_oe       = pin_oe_r;
endmodule

// >>> gsl_mux_chk.sv
// Purpose: Pin mux port checks
// Assumes: Pin g carries indicator g
// Notes:   Bound in testbench
`timescale 1ns/1ns
module gsl_mux_chk
  import gsl_pkg::*;
#(
  parameter int unsigned ACT_CYCLES = 16
) (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [5:0] pin_mode,
  input wire logic [2:0] pin_out_value,
  input wire logic       link_up,
  input wire logic       negotiating,
  input wire logic       speed_100,
  input wire logic       full_duplex,
  input wire logic       activity,
  input wire logic [2:0] status_indicators_n,
  input wire logic [2:0] pin_o,
  input wire logic [2:0] pin_oe
);
  localparam int AC = ACT_CYCLES;
  function automatic logic [2:0] md(logic [5:0] m, logic [1:0] c);
    for (int g = 0; g < 3; g++) md[g] = m[2*g+:2] == c;
  endfunction
  wire [2:0] pp = md(pin_mode, GSL_PIN_PUSH_PULL);
  wire [2:0] od = md(pin_mode, GSL_PIN_OPEN_DRAIN);
  wire [2:0] im = md(pin_mode, GSL_PIN_INDICATOR);
  wire [2:0] s  = status_indicators_n;
  wire       lv = link_up && !negotiating;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_speed_map: assert property (1 |=> s[0] == !$past(lv && speed_100))
    else $error("speed");
  a_duplex_map: assert property (1 |=> s[2] == !$past(link_up && full_duplex))
    else $error("duplex");
  a_link_dark: assert property (!lv |=> s[1]) else $error("dark");
  a_link_lit: assert property (lv && !s[1] && !activity |=> !s[1]) else $error("lit");
  a_act_pulse: assert property ($rose(s[1]) && $past(lv) ##0 (lv throughout ##AC 1)
    |-> !s[1] && $past(s[1])) else $error("pulse");
  a_pp_drive: assert property (1 |=>
    ((~pin_oe | pin_o ^ $past(pin_out_value)) & $past(pp)) == 3'h0) else $error("pp");
  a_od_drive: assert property (1 |=>
    ((pin_o | pin_oe ^ ~$past(pin_out_value)) & $past(od)) == 3'h0) else $error("od");
  a_ind_od: assert property ($stable(pin_mode) |=>
    ((pin_o | pin_oe ^ ~$past(s)) & $past(im)) == 3'h0) else $error("ind");
endmodule

// >>> gsl_pkg.sv
// Purpose: Types for the pin and status indicator mux
// Assumes: Constants come from gsl_cfg.svh
// Notes:   Types only
package gsl_pkg;
  typedef enum logic [1:0] {
    GSL_PIN_INPUT,
    GSL_PIN_PUSH_PULL,
    GSL_PIN_OPEN_DRAIN,
    GSL_PIN_INDICATOR
  } gsl_pin_mode_type;
  typedef enum logic [1:0] {
    GSL_ACT_SOLID,
    GSL_ACT_OFF,
    GSL_ACT_HOLD
  } gsl_act_state_type;
endpackage

// >>> testbench.sv
// Purpose: Pin mux bench
// Assumes: Blink period cut to 16
// Notes:   Board model on pins
`timescale 1ns/1ns
module testbench;
  import gsl_pkg::*;
  localparam int AC = 16;
  logic       clk, reset, link_up, negotiating, speed_100, full_duplex, activity;
  logic [5:0] pin_mode;
  logic [2:0] pin_out_value, ext_en, ext_v, pin_in_value;
  logic [2:0] status_indicators_n, pin_i, pin_o, pin_oe;
  int         failures, n_checks;
  gsl_gpio_led_mux #(.ACT_CYCLES(AC)) u_gsl_gpio_led_mux (.*);
  gsl_board u_gsl_board (.*);
  task automatic chk(string nm, logic [5:0] seen, logic [5:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic t_gpio(logic [2:0] ov, logic [5:0] eo, logic [2:0] ein);
    pin_mode <= {GSL_PIN_INPUT, GSL_PIN_OPEN_DRAIN, GSL_PIN_PUSH_PULL};
    pin_out_value <= ov;
    ext_en <= 3'h4;
    ext_v <= ov;
    cyc(1);
    #1 chk("pin_o pin_oe", {pin_o, pin_oe}, eo);
    cyc(4);
    #1 chk("pin_in_value", pin_in_value, ein);
    cyc(1);
  endtask
  task automatic t_status();
    logic [2:0] e;
    pin_mode <= 6'h3F;
    ext_en <= 3'h7;
    ext_v <= 3'h7;
    for (int i = 0; i < 16; i++) begin
      {link_up, negotiating, speed_100, full_duplex} <= i[3:0];
      e = ~{i[3] & i[0], i[3] & !i[2], i[3] & !i[2] & i[1]};
      cyc(4);
      #1 chk("indicators", {status_indicators_n, pin_oe}, {e, ~e});
      chk("pin_o pin_in_value", {pin_o, pin_in_value}, 6'h00);
      cyc(1);
    end
  endtask
  task automatic t_blink();
    {link_up, negotiating, activity} <= 3'h4;
    cyc(3);
    activity <= 1'b1;
    cyc(1);
    activity <= 1'b0;
    #1 chk("blink", status_indicators_n[1], 1'b1);
    cyc(AC - 1);
    #1 chk("blink", status_indicators_n[1], 1'b1);
    cyc(1);
    activity <= 1'b1;
    #1 chk("blink", status_indicators_n[1], 1'b0);
    cyc(AC - 2);
    #1 chk("blink", status_indicators_n[1], 1'b0);
    for (int k = 0; k < 4 && status_indicators_n[1] !== 1'b1; k++) #10;
    chk("blink", status_indicators_n[1], 1'b1);
    cyc(1);
    activity <= 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {reset, link_up, negotiating, speed_100, full_duplex, activity} = 6'h20;
    {pin_mode, pin_out_value, ext_en, ext_v} = 15'h0000;
    failures = 0;
    n_checks = 0;
    cyc(20);
    reset <= 1'b0;
    cyc(1);
    t_gpio(3'h2, 6'h01, 3'h2);
    t_gpio(3'h5, 6'h0B, 3'h5);
    t_status();
    t_blink();
    conclude();
  end
endmodule
bind gsl_gpio_led_mux gsl_mux_chk #(.ACT_CYCLES(ACT_CYCLES)) u_gsl_mux_chk (.*);
